/* design/ssc_top.sv */
`timescale 1ns/100ps
// Functional notes
// - Polarity 0: drive falling, sample rising
// - Overrun sets flag; buffer content undefined
// - Overrun raises no receive request
// - Transmit source bits: shared 0,1; ch2 bit4
// - Two-bit field picks prescaled source clock
// - Transmit enable always; receive enable to accept
// - Flags: buffer empty, shifter empty, complete
// - Continuous receive select enables continuous mode
// - Data invert select inverts both directions
// - Channel 1 clock may use two pins
// - Separation routes ch0 CTS from ch1 pin
// - Data output idles high before transfer
// - Open-drain data output floats while idle
// - Receive-only still shifts out dummy data
// - Transmit-only leaves data input free
// - Direction 0 drives clock; 1 takes input
// - Handshake pin: port, CTS input, RTS output
// - Unselected clock pin holds static idle level
// - Channel 2 data output is open-drain only
// - Rate is source over 2(n+1)
// - Overrun flagged at next word's seventh bit
// - Start needs enable, data, low CTS
module ssc_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input logic clk_i,
  input logic rst_i,
  // Wishbone slave
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [ADDR_W-1:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial data pins
  input logic [2:0] serial_data_in_i,
  output logic [2:0] serial_data_out_o,
  output logic [2:0] serial_data_out_oe_n_o,
  // Transfer clock pins
  input logic [2:0] transfer_clock_pin_i,
  output logic [2:0] transfer_clock_pin_o,
  output logic [2:0] transfer_clock_pin_oe_n_o,
  output logic alt_clock_pin_o,
  output logic alt_clock_pin_oe_n_o,
  // Handshake pins
  input logic [2:0] handshake_pin_i,
  output logic [2:0] handshake_pin_o,
  output logic [2:0] handshake_pin_oe_n_o,
  // Request strobes to the interrupt controller
  output logic [2:0] tx_irq_o,
  output logic [2:0] rx_irq_o
);
  import ssc_pkg::*;

  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  logic [7:0] brg [SSC_NCH];
  logic [7:0] mr [SSC_NCH];
  logic [7:0] c0 [SSC_NCH];
  logic [7:0] c1 [SSC_NCH];
  logic [7:0] smr [SSC_NCH][4];
  logic [7:0] tb [SSC_NCH];
  logic [7:0] rb [SSC_NCH];
  logic [7:0] rx_word [SSC_NCH];
  logic [7:0] shared_serial_control;
  logic [SSC_NCH-1:0] tb_full, ri, ovr, ovr_word;
  logic [SSC_NCH-1:0] en, load, busy, done, ovr_p, sclk, txd, tick, start_ok;
  logic [SSC_NCH-1:0] cts_used, cts_n, rrm, irs, od;
  ssc_cfg_s cfg [SSC_NCH];
  logic [PRE_W-1:0] pre;
  logic [1:0] a_ch;
  logic [5:0] a_off;
  logic hit, wr, rd, multi, clk_sel;
  logic [31:0] next_dat;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: ack one cycle after request, single cycle high
  assign a_ch = wb_adr_i[7:6];
  assign a_off = wb_adr_i[5:0];
  assign hit = ((wb_adr_i >> 8) == '0);
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && hit;
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o && hit;

  function automatic logic sel_ch(input logic [1:0] c, input int i);
    return c == i[1:0];
  endfunction : sel_ch

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= next_dat;
      end
    end
  end

  always_comb begin
    next_dat = 32'h0000_0000;
    if (hit && a_ch == SHARED_SERIAL_CONTROL_CH && a_off == OFF_SHARED_SERIAL_CONTROL) begin
      next_dat[7:0] = shared_serial_control;
    end
    for (int i = 0; i < SSC_NCH; i++) begin
      if (hit && sel_ch(a_ch, i)) begin
        case (a_off)
          OFF_RB: begin
            next_dat[7:0] = rb[i] ^ {8{c1[i][C1_INV]}};
            next_dat[RB_OVR] = ovr[i];
          end
          OFF_BRG: next_dat[7:0] = brg[i];
          OFF_MR: next_dat[7:0] = mr[i];
          OFF_C0: begin
            next_dat[7:0] = c0[i];
            next_dat[C0_SHIFT_REG_EMPTY_FLAG] = !busy[i];
          end
          OFF_C1: begin
            next_dat[7:0] = c1[i];
            next_dat[C1_TBE] = !tb_full[i];
            next_dat[C1_RI] = ri[i];
          end
          OFF_SMA: next_dat[7:0] = smr[i][0];
          OFF_SMB: next_dat[7:0] = smr[i][1];
          OFF_SMC: next_dat[7:0] = smr[i][2];
          OFF_SMD: next_dat[7:0] = smr[i][3];
          default: next_dat = 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; read-only bits are kept out of storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shared_serial_control <= REG_RST;
      for (int i = 0; i < SSC_NCH; i++) begin
        brg[i] <= REG_RST;
        mr[i] <= REG_RST;
        c0[i] <= REG_RST;
        c1[i] <= REG_RST;
        tb[i] <= REG_RST;
        for (int k = 0; k < 4; k++) begin
          smr[i][k] <= REG_RST;
        end
      end
    end else if (wr) begin
      if (a_ch == SHARED_SERIAL_CONTROL_CH && a_off == OFF_SHARED_SERIAL_CONTROL) begin
        shared_serial_control <= wb_dat_i[7:0];
      end
      for (int i = 0; i < SSC_NCH; i++) begin
        if (sel_ch(a_ch, i)) begin
          case (a_off)
            OFF_TB: tb[i] <= wb_dat_i[7:0];
            OFF_BRG: brg[i] <= wb_dat_i[7:0];
            OFF_MR: mr[i] <= wb_dat_i[7:0];
            OFF_C0: c0[i] <= wb_dat_i[7:0] & ~(8'h01 << C0_SHIFT_REG_EMPTY_FLAG);
            OFF_C1: c1[i] <= wb_dat_i[7:0] & ~((8'h01 << C1_TBE) | (8'h01 << C1_RI));
            OFF_SMA: smr[i][0] <= wb_dat_i[7:0];
            OFF_SMB: smr[i][1] <= wb_dat_i[7:0];
            OFF_SMC: smr[i][2] <= wb_dat_i[7:0];
            OFF_SMD: smr[i][3] <= wb_dat_i[7:0];
            default: ;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler shared by all channels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre <= '0;
    end else begin
      pre <= pre + 1'b1;
    end
  end

  // source select: divide by 1, 2, 8, 32
  function automatic logic src_tick(input logic [1:0] s, input logic [PRE_W-1:0] p);
    case (s)
      2'h0: return 1'b1;
      2'h1: return p[0];
      2'h2: return &p[2:0];
      default: return &p;
    endcase
  endfunction : src_tick

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel setup and shifters
  assign multi = shared_serial_control[UC_MULTI];
  assign clk_sel = shared_serial_control[UC_CLKSEL];

  for (genvar g = 0; g < SSC_NCH; g++) begin : g_ch
    // only mode 001 runs the channel
    assign en[g] = (mr[g][2:0] == MODE_SYNC);
    assign cfg[g] = '{en: en[g], clock_direction_sel: mr[g][MR_CLOCK_DIRECTION_SEL], clock_polarity_sel: c0[g][C0_CLOCK_POLARITY_SEL],
                      msb: c0[g][C0_MSB], inv: c1[g][C1_INV], brg: brg[g]};
    assign tick[g] = src_tick(c0[g][C0_SRC+1:C0_SRC], pre);
    if (g < 2) begin : g_shared
      assign irs[g] = shared_serial_control[UC_IRS0+g];
      assign rrm[g] = shared_serial_control[UC_RRM0+g];
    end else begin : g_own
      assign irs[g] = c1[g][C1_IRS2];
      assign rrm[g] = c1[g][C1_RRM2];
    end
    // channel 0 may take CTS from channel 1's pin
    if (g == 0) begin : g_sep
      assign cts_n[g] = shared_serial_control[UC_SEP] ? handshake_pin_i[1] : handshake_pin_i[0];
      assign cts_used[g] = !c0[g][C0_HS_DIS] && (!c0[g][C0_HS_TYPE] || shared_serial_control[UC_SEP]);
    end else begin : g_nosep
      assign cts_n[g] = handshake_pin_i[g];
      assign cts_used[g] = !c0[g][C0_HS_DIS] && !c0[g][C0_HS_TYPE];
    end
    assign start_ok[g] = c1[g][C1_TE] && tb_full[g] && !(cts_used[g] && cts_n[g]);

    ssc_shifter u_shift (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cfg_i(cfg[g]),
      .src_tick_i(tick[g]),
      .start_ok_i(start_ok[g]),
      .tx_data_i(tb[g]),
      .rx_en_i(c1[g][C1_RE]),
      .rb_full_i(ri[g]),
      .ext_clk_i(transfer_clock_pin_i[g]),
      .rxd_i(serial_data_in_i[g]),
      .sclk_o(sclk[g]),
      .txd_o(txd[g]),
      .load_o(load[g]),
      .busy_o(busy[g]),
      .done_o(done[g]),
      .ovr_o(ovr_p[g]),
      .rx_data_o(rx_word[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tb_full <= '0;
      ri <= '0;
      ovr <= '0;
      ovr_word <= '0;
      for (int i = 0; i < SSC_NCH; i++) begin
        rb[i] <= REG_RST;
      end
    end else begin
      for (int i = 0; i < SSC_NCH; i++) begin
        if (!en[i]) begin
          tb_full[i] <= 1'b0;
          ri[i] <= 1'b0;
          ovr[i] <= 1'b0;
          ovr_word[i] <= 1'b0;
        end else begin
          if (wr && sel_ch(a_ch, i) && a_off == OFF_TB) begin
            tb_full[i] <= 1'b1;
          end else if (rd && rrm[i] && sel_ch(a_ch, i) && a_off == OFF_RB) begin
            tb_full[i] <= 1'b1;
          end else if (load[i]) begin
            tb_full[i] <= 1'b0;
          end
          // data input only used when receiving
          if (done[i] && c1[i][C1_RE]) begin
            rb[i] <= rx_word[i];
            ri[i] <= 1'b1;
          end else if (rd && sel_ch(a_ch, i) && a_off == OFF_RB) begin
            ri[i] <= 1'b0;
          end
          // overrun flag is sticky until mode off
          if (ovr_p[i]) begin
            ovr[i] <= 1'b1;
            ovr_word[i] <= 1'b1;
          end else if (load[i]) begin
            ovr_word[i] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_irq_o <= '0;
      rx_irq_o <= '0;
    end else begin
      for (int i = 0; i < SSC_NCH; i++) begin
        tx_irq_o[i] <= irs[i] ? done[i] : load[i];
        // no receive request for an overrun word
        rx_irq_o[i] <= done[i] && c1[i][C1_RE] && !ovr_word[i] && !ovr_p[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins; enables are low while driving
  logic [2:0] clk_val, clk_drv, clk_od;
  for (genvar g = 0; g < SSC_NCH; g++) begin : g_pin
    assign od[g] = (g == 2) || c0[g][C0_OD];
    assign serial_data_out_o[g] = od[g] ? 1'b0 : txd[g];
    assign serial_data_out_oe_n_o[g] = !en[g] || (od[g] && txd[g]);
    // direction picks output or input clock
    assign clk_drv[g] = en[g] && !mr[g][MR_CLOCK_DIRECTION_SEL];
    assign clk_od[g] = smr[g][2][SMC_CLK_OD];
    // unselected pin holds the idle level
    if (g == 1) begin : g_multi
      assign clk_val[g] = (multi && clk_sel) ? !c0[g][C0_CLOCK_POLARITY_SEL] : sclk[g];
    end else begin : g_single
      assign clk_val[g] = sclk[g];
    end
    assign transfer_clock_pin_o[g] = clk_od[g] ? 1'b0 : clk_val[g];
    assign transfer_clock_pin_oe_n_o[g] = !clk_drv[g] || (clk_od[g] && clk_val[g]);
    // handshake pin role; RTS low when ready
    if (g == 1) begin : g_hs1
      assign handshake_pin_oe_n_o[g] = !(en[g] && !c0[g][C0_HS_DIS] && c0[g][C0_HS_TYPE])
                                       || multi;
    end else begin : g_hsn
      assign handshake_pin_oe_n_o[g] = !(en[g] && !c0[g][C0_HS_DIS] && c0[g][C0_HS_TYPE]);
    end
    assign handshake_pin_o[g] = !(c1[g][C1_RE] && !ri[g] && !busy[g]);
  end

  // second clock pin for channel 1
  assign alt_clock_pin_o = clk_sel ? sclk[1] : !c0[1][C0_CLOCK_POLARITY_SEL];
  assign alt_clock_pin_oe_n_o = !(multi && clk_drv[1]);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_ovr_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ovr_p[0] && en[0] |=> ovr[0] && !rx_irq_o[0]) else $error("overrun flag not set");
  a_ri_on_store: assert property (@(posedge clk_i) disable iff (rst_i)
    done[0] && c1[0][C1_RE] && en[0] |=> ri[0] && rb[0] == $past(rx_word[0]))
    else $error("word not stored with complete flag");
  a_tbe_on_load: assert property (@(posedge clk_i) disable iff (rst_i)
    load[0] && !wr && !rd |=> !tb_full[0]) else $error("buffer empty flag not set at load");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
  a_no_irq_ovr: assert property (@(posedge clk_i) disable iff (rst_i)
    ovr_word[0] && !load[0] |-> ##1 !rx_irq_o[0]) else $error("receive request on overrun");
  a_hs_released: assert property (@(posedge clk_i) disable iff (rst_i)
    c0[0][C0_HS_DIS] |-> handshake_pin_oe_n_o[0]) else $error("handshake pin driven when off");
  a_cts_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    load[0] |-> !(cts_used[0] && cts_n[0]) && c1[0][C1_TE]) else $error("start while CTS high");
  a_ch2_od_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !busy[2] |-> serial_data_out_oe_n_o[2]) else $error("channel 2 idle line not released");
  a_alt_static: assert property (@(posedge clk_i) disable iff (rst_i)
    multi && !clk_sel |-> alt_clock_pin_o == !c0[1][C0_CLOCK_POLARITY_SEL]) else $error("alt pin not static");

endmodule : ssc_top

/* inc/ssc_pkg.sv */
package ssc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry and map
  localparam int SSC_NCH = 3;
  localparam logic [5:0] OFF_TB = 6'h00;
  localparam logic [5:0] OFF_RB = 6'h04;
  localparam logic [5:0] OFF_BRG = 6'h08;
  localparam logic [5:0] OFF_MR = 6'h0C;
  localparam logic [5:0] OFF_C0 = 6'h10;
  localparam logic [5:0] OFF_C1 = 6'h14;
  localparam logic [5:0] OFF_SMA = 6'h18;
  localparam logic [5:0] OFF_SMB = 6'h1C;
  localparam logic [5:0] OFF_SMC = 6'h20;
  localparam logic [5:0] OFF_SMD = 6'h24;
  localparam logic [1:0] SHARED_SERIAL_CONTROL_CH = 2'h3;
  localparam logic [5:0] OFF_SHARED_SERIAL_CONTROL = 6'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [2:0] MODE_SYNC = 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int MR_CLOCK_DIRECTION_SEL = 3;
  localparam int C0_SRC = 0;
  localparam int C0_HS_TYPE = 2;
  localparam int C0_SHIFT_REG_EMPTY_FLAG = 3;
  localparam int C0_HS_DIS = 4;
  localparam int C0_OD = 5;
  localparam int C0_CLOCK_POLARITY_SEL = 6;
  localparam int C0_MSB = 7;
  localparam int C1_TE = 0;
  localparam int C1_TBE = 1;
  localparam int C1_RE = 2;
  localparam int C1_RI = 3;
  localparam int C1_IRS2 = 4;
  localparam int C1_RRM2 = 5;
  localparam int C1_INV = 6;
  localparam int UC_IRS0 = 0;
  localparam int UC_RRM0 = 2;
  localparam int UC_CLKSEL = 4;
  localparam int UC_MULTI = 5;
  localparam int UC_SEP = 6;
  localparam int SMC_CLK_OD = 5;
  localparam int RB_OVR = 12;
  localparam int PRE_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Channel setup carried to the shifter
  typedef struct packed {
    logic en;
    logic clock_direction_sel;
    logic clock_polarity_sel;
    logic msb;
    logic inv;
    logic [7:0] brg;
  } ssc_cfg_s;

  function automatic logic [7:0] ssc_rev8(input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < 8; k++) begin
      r[k] = d[7-k];
    end
    return r;
  endfunction : ssc_rev8

endpackage : ssc_pkg

/* design/ssc_shifter.sv */
`timescale 1ns/100ps
module ssc_shifter (
  // Clock and reset
  input logic clk_i,
  input logic rst_i,
  // Setup and start
  input ssc_pkg::ssc_cfg_s cfg_i,
  input logic src_tick_i,
  input logic start_ok_i,
  input logic [7:0] tx_data_i,
  input logic rx_en_i,
  input logic rb_full_i,
  // Serial side
  input logic ext_clk_i,
  input logic rxd_i,
  output logic sclk_o,
  output logic txd_o,
  // Events and status
  output logic load_o,
  output logic busy_o,
  output logic done_o,
  output logic ovr_o,
  output logic [7:0] rx_data_o
);
  import ssc_pkg::*;

  logic busy, lvl, ext_q, txd;
  logic [7:0] cnt, tsh, rsh;
  logic [3:0] nbits;
  logic start, tog, lead, trail, ext_lvl;
  logic [7:0] word_in;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection, normalised so that idle level is 1
  assign ext_lvl = ext_clk_i ^ cfg_i.clock_polarity_sel;
  // start needs enable, data, clear to send
  assign start = cfg_i.en && !busy && start_ok_i;
  assign tog = busy && !cfg_i.clock_direction_sel && src_tick_i && (cnt == 8'h00);
  // lead edge drives, trail edge samples
  assign lead = busy && (cfg_i.clock_direction_sel ? (ext_q && !ext_lvl) : (tog && lvl));
  assign trail = busy && (cfg_i.clock_direction_sel ? (!ext_q && ext_lvl) : (tog && !lvl));
  // Receive inversion is applied at the buffer read, not here
  assign word_in = {rxd_i, rsh[7:1]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_q <= 1'b1;
    end else begin
      ext_q <= ext_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud divider: toggles every n+1 source ticks
  // half period of n plus one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
      lvl <= 1'b1;
    end else begin
      if (!busy || (src_tick_i && cnt == 8'h00)) begin
        cnt <= cfg_i.brg;
      end else if (src_tick_i) begin
        cnt <= cnt - 8'h01;
      end
      if (!busy) begin
        lvl <= 1'b1;
      end else if (tog) begin
        lvl <= ~lvl;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      nbits <= 4'h0;
    end else if (!cfg_i.en) begin
      busy <= 1'b0;
      nbits <= 4'h0;
    end else if (start) begin
      busy <= 1'b1;
      nbits <= 4'h0;
    end else if (trail) begin
      nbits <= nbits + 4'h1;
      if (nbits == 4'h7) begin
        busy <= 1'b0;
      end
    end
  end

  // invert and order applied at load
  // buffer content shifts out even when receiving only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tsh <= 8'h00;
      txd <= 1'b1;
    end else if (start) begin
      tsh <= (cfg_i.msb ? ssc_rev8(tx_data_i) : tx_data_i) ^ {8{cfg_i.inv}};
    end else if (!busy) begin
      txd <= 1'b1;
    end else if (lead) begin
      txd <= tsh[0];
      tsh <= {1'b0, tsh[7:1]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsh <= 8'h00;
      rx_data_o <= 8'h00;
      done_o <= 1'b0;
      ovr_o <= 1'b0;
    end else begin
      done_o <= trail && (nbits == 4'h7);
      ovr_o <= trail && (nbits == 4'h6) && rb_full_i && rx_en_i;
      if (trail) begin
        rsh <= word_in;
        if (nbits == 4'h7) begin
          rx_data_o <= cfg_i.msb ? ssc_rev8(word_in) : word_in;
        end
      end
    end
  end

  assign sclk_o = lvl ^ cfg_i.clock_polarity_sel;
  assign txd_o = txd;
  assign load_o = start;
  assign busy_o = busy;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_idle_txd_high: assert property (@(posedge clk_i) disable iff (rst_i)
    !busy && !$past(busy) |-> txd_o) else $error("data line not high while idle");
  a_start_needs_ok: assert property (@(posedge clk_i) disable iff (rst_i)
    load_o |-> start_ok_i && cfg_i.en) else $error("start without condition");
  a_load_then_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    load_o |=> busy_o ##1 busy_o) else $error("load did not begin a transfer");
  a_clock_idle_lvl: assert property (@(posedge clk_i) disable iff (rst_i)
    !busy && !cfg_i.clock_direction_sel |-> sclk_o == !cfg_i.clock_polarity_sel) else $error("clock idle level wrong");

endmodule : ssc_shifter

/* verif/ssc_peer.sv */
`timescale 1ns/100ps
module ssc_peer (
  // Clocks
  input wire logic clk_i,
  input wire logic sclk_i,
  // Data
  input wire logic txd_i,
  input wire logic [7:0] byte_i,
  output logic rxd_o,
  output logic [7:0] got_o
);
  int cnt = 8;
  int rcv = 8;
  logic [7:0] sh = 8'h00;
  initial rxd_o = 1'b0;
  initial got_o = 8'h00;
  always @(negedge sclk_i) begin
    if (cnt == 8) begin
      sh = byte_i;
      cnt = 0;
      rcv = 0;
    end
    rxd_o <= sh[cnt];
    cnt++;
  end
  // sample on trail edge; stray edges outside a frame are ignored
  always @(posedge sclk_i) begin
    if (rcv < 8) begin
      got_o <= {txd_i, got_o[7:1]};
      rcv++;
    end
  end
  // No hold between frames, so a stale bit never reads as good
  always @(posedge clk_i) begin
    if (cnt == 8 && rcv == 8) begin
      rxd_o <= ~rxd_o;
    end
  end
endmodule : ssc_peer

/* verif/test_sync_serial_channel.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_sync_serial_channel;
  import ssc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic cts = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [7:0] pbyte = 8'h00;
  logic [31:0] rdat, r;
  logic ack, rxd, sclk, alt, alt_oe_n;
  logic [2:0] hso, hso_oe_n;
  logic [7:0] got;
  logic [2:0] sdo, sdo_oe_n, cko, cko_oe_n, txi, rxi;
  int error_cnt = 0;
  int checks = 0;
  int rx_cnt = 0;
  int tx_cnt = 0;
  logic [23:0] rows [6] = '{24'h08_A5A5, 24'h0C_0808, 24'h18_5A5A, 24'h24_C3C3,
    24'hC0_2020, 24'h3C_FF00};

  always #5 clk_i = ~clk_i;
  // Pull-up on the clock pin while nobody drives it
  assign sclk = (cko_oe_n[0] === 1'b0) ? cko[0] : 1'b1;

  // external clock pins held at the idle high level
  // Channel 1's CTS pin sits low to feed the separated path of channel 0
  ssc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_data_in_i({2'b11, rxd}), .serial_data_out_o(sdo), .serial_data_out_oe_n_o(sdo_oe_n),
    .transfer_clock_pin_i(3'b111), .transfer_clock_pin_o(cko),
    .transfer_clock_pin_oe_n_o(cko_oe_n), .alt_clock_pin_o(alt), .alt_clock_pin_oe_n_o(alt_oe_n),
    .handshake_pin_i({2'b10, cts}), .handshake_pin_o(hso), .handshake_pin_oe_n_o(hso_oe_n),
    .tx_irq_o(txi), .rx_irq_o(rxi));
  ssc_peer u_peer (.clk_i(clk_i), .sclk_i(sclk), .txd_i(sdo[0]), .byte_i(pbyte),
    .rxd_o(rxd), .got_o(got));

  always @(posedge clk_i) begin
    if (rxi[0] === 1'b1) rx_cnt++;
    if (txi[0] === 1'b1) tx_cnt++;
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic wait_bit(input logic [7:0] a, input int b);
    int i;
    i = 0;
    do begin
      bus(1'b0, a, 8'h00);
      i++;
    end while (r[b] !== 1'b1 && i < 80);
  endtask : wait_bit

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    print_verdict;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("data oe_n", 3'b111, sdo_oe_n)
    `CHK("clk oe_n", 3'b111, cko_oe_n)
    foreach (rows[k]) begin
      bus(1'b0, rows[k][23:16], 8'h00);
      `CHK("reset val", REG_RST, r[7:0])
      bus(1'b1, rows[k][23:16], rows[k][15:8]);
      bus(1'b0, rows[k][23:16], 8'h00);
      `CHK("readback", rows[k][7:0], r[7:0])
    end
    `CHK("alt pin", 2'b11, {alt, alt_oe_n})
    bus(1'b1, 8'h18, 8'h00);
    bus(1'b1, 8'h24, 8'h00);
    bus(1'b1, 8'h08, 8'h00);
    bus(1'b1, 8'hC0, 8'h00);
    bus(1'b1, 8'h10, 8'h10);
    bus(1'b1, 8'h14, 8'h05);
    bus(1'b1, 8'h0C, 8'h01);
    @(posedge clk_i);
    `CHK("idle data", 1'b1, sdo[0])
    `CHK("data oe", 1'b0, sdo_oe_n[0])
    `CHK("idle clk", 1'b1, cko[0])
    `CHK("clk oe", 1'b0, cko_oe_n[0])
    pbyte <= 8'hC5;
    bus(1'b1, 8'h00, 8'h3A);
    wait_bit(8'h14, 3);
    `CHK("tx byte", 8'h3A, got)
    `CHK("c1 flags", 2'b11, {r[3], r[1]})
    `CHK("tx irq", 1, tx_cnt)
    `CHK("rx irq", 1, rx_cnt)
    // Second word lands while the first is unread
    pbyte <= 8'h96;
    bus(1'b1, 8'h00, 8'h0F);
    wait_bit(8'h10, 3);
    bus(1'b0, 8'h04, 8'h00);
    `CHK("overrun", 1'b1, r[RB_OVR])
    `CHK("no rx irq", 1, rx_cnt)
    bus(1'b1, 8'h0C, 8'h00);
    bus(1'b1, 8'h0C, 8'h01);
    bus(1'b1, 8'h14, 8'h45);
    pbyte <= 8'h5A;
    bus(1'b1, 8'h00, 8'h3A);
    wait_bit(8'h14, 3);
    `CHK("inv tx", 8'hC5, got)
    bus(1'b0, 8'h04, 8'h00);
    `CHK("inv rx", 8'hA5, r[7:0])
    `CHK("rx irq 2", 2, rx_cnt)
    bus(1'b1, 8'h10, 8'h00);
    cts <= 1'b1;
    bus(1'b1, 8'h00, 8'h11);
    repeat (40) @(posedge clk_i);
    bus(1'b0, 8'h14, 8'h00);
    `CHK("cts hold", 1'b0, r[1])
    cts <= 1'b0;
    wait_bit(8'h14, 3);
    `CHK("cts go", 1'b1, r[1])
    // Separated CTS with continuous receive: own CTS pin held high
    bus(1'b0, 8'h04, 8'h00);
    bus(1'b1, 8'h10, 8'h04);
    bus(1'b1, 8'h50, 8'h00);
    cts <= 1'b1;
    bus(1'b1, 8'hC0, 8'h44);
    `CHK("rts pin", 2'b00, {hso[0], hso_oe_n[0]})
    bus(1'b0, 8'h04, 8'h00);
    wait_bit(8'h14, 3);
    `CHK("cont rx", 1'b1, r[3])
    `CHK("sep tx", 8'hEE, got)
    print_verdict;
  end
endmodule : test_sync_serial_channel
